// >>> rtl/aspo_pkg.sv
// shared constants and types for the converter output port
package aspo_pkg;
    localparam int WORD = 16;
    localparam int CLK_HZ = 20_000_000;
    // read-overrun flag pulse width, in ns and in clk cycles (rounded up)
    localparam int OVR_PULSE_NS = 100;
    localparam int OVR_PULSE_CYC = (OVR_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam logic [7:0] DIV_RST = 8'h04;
    // apb byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_RESULT = 8'h08;
    // field positions
    localparam int CTRL_DIV_LSB = 0;
    localparam int STAT_BUSY = 0;
    localparam int STAT_SHIFT = 1;
    localparam int STAT_OVR_LSB = 8;
    localparam int RESULT_LSB = 0;
    // shared pin indices on the 12-bit low data bus
    localparam int PIN_CLKSRC = 4;
    localparam int PIN_SYNCPOL = 5;
    localparam int PIN_SCKINV = 6;
    localparam int PIN_RDC = 7;
    localparam int PIN_SDO = 8;
    localparam int PIN_SCLK = 9;
    localparam int PIN_FRAME = 10;
    localparam int PIN_OVR = 11;
    localparam int LOW_PINS = 12;
    typedef enum logic [1:0] {
        SS_IDLE  = 2'h0,
        SS_HOLD  = 2'h1,
        SS_SHIFT = 2'h3
    } aspo_ser_state_t;
endpackage

// >>> rtl/aspo_sync.sv
// two-flop synchroniser for a vector of asynchronous levels
`timescale 1ns/1ns
module aspo_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         arst_n_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule

// >>> rtl/aspo_apb_regs.sv
// apb register slave: clock divider control, status and result readback
`timescale 1ns/1ns
module aspo_apb_regs (
    input  wire logic                   clk_i,
    input  wire logic                   arst_n_i,
    input  wire logic [7:0]             paddr,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    output logic      [7:0]             div_o,
    input  wire logic                   busy_i,
    input  wire logic                   shift_i,
    input  wire logic [7:0]             ovr_cnt_i,
    input  wire logic [aspo_pkg::WORD-1:0] result_i
);
    import aspo_pkg::*;

    logic [7:0]  div_q;
    logic [7:0]  div_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic        hit;

    always_comb begin
        hit = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_RESULT);
        div_d = div_q;
        rdata_d = rdata_q;
        // write takes effect in the access phase
        if (psel && penable && pwrite && paddr == REG_CTRL) begin
            div_d = pwdata[CTRL_DIV_LSB +: 8];
        end
        // read data captured in the setup phase
        if (psel && !penable) begin
            rdata_d = 32'h0;
            case (paddr)
                REG_CTRL: begin
                    rdata_d[CTRL_DIV_LSB +: 8] = div_q;
                end
                REG_STAT: begin
                    rdata_d[STAT_BUSY] = busy_i;
                    rdata_d[STAT_SHIFT] = shift_i;
                    rdata_d[STAT_OVR_LSB +: 8] = ovr_cnt_i;
                end
                REG_RESULT: begin
                    rdata_d[RESULT_LSB +: WORD] = result_i;
                end
                default: begin
                    rdata_d = 32'h0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            div_q <= DIV_RST;
            rdata_q <= 32'h0;
        end else begin
            div_q <= div_d;
            rdata_q <= rdata_d;
        end
    end

    assign prdata = rdata_q;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !hit;
    assign div_o = div_q;
endmodule

// >>> rtl/aspo_top.sv
// converter result output port: parallel bus and serial master/slave
// How it works
// RULE_01: parallel mode drives result bits on shared pins
// RULE_02: bits 12 to 15 always driven
// RULE_03: serial mode puts result on bit-8 pin
// RULE_04: chain input appears after 16 clocks
// RULE_05: read mode picks during or after conversion
// RULE_06: result shifted out msb first
// RULE_07: serial word coding follows coding pin
// RULE_08: internal clock: bit stable over both edges
// RULE_09: external clock, no invert: change on rise
// RULE_10: external clock, invert: change on fall
// RULE_11: clock pin output internal, input external
// RULE_12: frame marker only with internal clock
// RULE_13: polarity low: marker high during data
// RULE_14: polarity high: marker low during data
// RULE_15: slave overrun drops data, pulses flag
// RULE_16: coding low inverts msb for twos complement
// RULE_17: clock source low internal, high external
// RULE_18: busy from start until result latched
// RULE_19: chip-select and read low enable output
// RULE_20: host clocks sixteen bits per result
`timescale 1ns/1ns
module aspo_top (
    input  wire logic                      clk_i,
    input  wire logic                      arst_n_i,
    input  wire logic [7:0]                paddr,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [31:0]               pwdata,
    output logic      [31:0]               prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic                      cnv_start_i,
    input  wire logic                      cnv_done_i,
    input  wire logic [aspo_pkg::WORD-1:0] cnv_data_i,
    input  wire logic                      reset_pin_i,
    input  wire logic                      port_type_select_i,
    input  wire logic                      output_coding_select_i,
    input  wire logic                      cs_n_i,
    input  wire logic                      rd_n_i,
    input  wire logic [aspo_pkg::LOW_PINS-1:0] d_i,
    output logic      [aspo_pkg::LOW_PINS-1:0] d_o,
    output logic      [aspo_pkg::LOW_PINS-1:0] d_oe_n_o,
    output logic      [3:0]                d_hi_o,
    output logic                           busy_o
);
    import aspo_pkg::*;

    function automatic logic [WORD-1:0] code_word(input logic [WORD-1:0] raw, input logic straight);
        code_word = raw;
        code_word[WORD-1] = raw[WORD-1] ^ ~straight; // RULE_16
    endfunction

    // synchronised pin levels
    logic [9:0] pins_s;
    logic       rst_pin;
    logic       serial_mode;
    logic       coding_straight;
    logic       cs_n_s;
    logic       rd_n_s;
    logic       sclk_in;
    logic       read_mode;
    logic       sck_inv;
    logic       sync_pol;
    logic       ext_clk;

    aspo_sync #(.W(10)) u_sync (
        .clk_i    (clk_i),
        .arst_n_i (arst_n_i),
        .d_i      ({reset_pin_i, port_type_select_i, output_coding_select_i, cs_n_i, rd_n_i,
                    d_i[PIN_SCLK], d_i[PIN_RDC], d_i[PIN_SCKINV], d_i[PIN_SYNCPOL], d_i[PIN_CLKSRC]}),
        .q_o      (pins_s)
    );

    assign rst_pin = pins_s[9];
    assign serial_mode = pins_s[8];
    assign coding_straight = pins_s[7];
    assign cs_n_s = pins_s[6];
    assign rd_n_s = pins_s[5];
    assign sclk_in = pins_s[4];
    assign read_mode = pins_s[3];
    assign sck_inv = pins_s[2];
    assign sync_pol = pins_s[1];
    assign ext_clk = pins_s[0];

    // register slave
    logic [7:0] div;
    logic [7:0] ovr_cnt_q, ovr_cnt_d;
    logic [WORD-1:0] par_q, par_d;
    logic busy_q, busy_d;
    aspo_ser_state_t st_q, st_d;

    aspo_apb_regs u_regs (
        .clk_i     (clk_i),
        .arst_n_i  (arst_n_i),
        .paddr     (paddr),
        .psel      (psel),
        .penable   (penable),
        .pwrite    (pwrite),
        .pwdata    (pwdata),
        .prdata    (prdata),
        .pready    (pready),
        .pslverr   (pslverr),
        .div_o     (div),
        .busy_i    (busy_q),
        .shift_i   (st_q == SS_SHIFT),
        .ovr_cnt_i (ovr_cnt_q),
        .result_i  (par_q)
    );

    // serial state
    logic [WORD-1:0] sreg_q, sreg_d;
    logic [7:0] tick_q, tick_d;
    logic [1:0] qtr_q, qtr_d;
    logic [3:0] bit_q, bit_d;
    logic [7:0] scnt_q, scnt_d;
    logic       sclk_prev_q;
    logic [1:0] ovr_pulse_q, ovr_pulse_d;
    logic [LOW_PINS-1:0] dout_q, dout_d;
    logic [LOW_PINS-1:0] doe_n_q, doe_n_d;
    logic master, slave, out_en, tick, act_edge, reading, sclk_int, frame;
    logic [WORD-1:0] coded;

    always_comb begin
        master = serial_mode && !ext_clk; // RULE_17
        slave = serial_mode && ext_clk;
        out_en = !cs_n_s && !rd_n_s; // RULE_19
        tick = (tick_q == 8'h0);
        // slave active edge, external clock gated by chip-select
        act_edge = slave && !cs_n_s && (sck_inv ? (sclk_prev_q && !sclk_in) // RULE_10
                                                : (!sclk_prev_q && sclk_in)); // RULE_09
        reading = (scnt_q != 8'h0) && (scnt_q < 8'(WORD));
        coded = code_word(cnv_data_i, coding_straight); // RULE_07
        sclk_int = (st_q == SS_SHIFT) && (qtr_q == 2'h1 || qtr_q == 2'h2);
        frame = (st_q == SS_SHIFT) ^ sync_pol; // RULE_13 RULE_14

        busy_d = busy_q;
        par_d = par_q;
        st_d = st_q;
        sreg_d = sreg_q;
        tick_d = tick ? div : tick_q - 8'h1;
        qtr_d = qtr_q;
        bit_d = bit_q;
        scnt_d = scnt_q;
        ovr_pulse_d = (ovr_pulse_q != 2'h0) ? ovr_pulse_q - 2'h1 : 2'h0;
        ovr_cnt_d = ovr_cnt_q;

        if (cnv_start_i) begin
            busy_d = 1'b1; // RULE_18
            if (master && st_q == SS_HOLD) begin
                st_d = SS_SHIFT; // RULE_05
                qtr_d = 2'h0;
                bit_d = 4'h0;
            end
        end

        // master shift: data changes only at quarter 0, clock high in quarters 1-2
        if (st_q == SS_SHIFT && tick) begin
            qtr_d = qtr_q + 2'h1;
            if (qtr_q == 2'h3) begin
                sreg_d = {sreg_q[WORD-2:0], 1'b0}; // RULE_06 RULE_08
                if (bit_q == 4'(WORD - 1)) begin
                    st_d = SS_IDLE;
                end else begin
                    bit_d = bit_q + 4'h1;
                end
            end
        end

        if (act_edge) begin
            sreg_d = {sreg_q[WORD-2:0], read_mode}; // RULE_04
            scnt_d = (scnt_q == 8'hff) ? scnt_q : scnt_q + 8'h1;
        end

        if (cnv_done_i) begin
            busy_d = 1'b0; // RULE_18
            par_d = coded;
            sreg_d = coded;
            scnt_d = 8'h0;
            if (slave && reading) begin
                ovr_pulse_d = 2'(OVR_PULSE_CYC); // RULE_15
                ovr_cnt_d = ovr_cnt_q + 8'h1;
            end
            if (master) begin
                st_d = read_mode ? SS_HOLD : SS_SHIFT; // RULE_05
                qtr_d = 2'h0;
                bit_d = 4'h0;
            end else begin
                st_d = SS_IDLE;
            end
        end

        if (rst_pin) begin
            busy_d = 1'b0;
            st_d = SS_IDLE;
            scnt_d = 8'h0;
            ovr_pulse_d = 2'h0;
        end

        // pin drivers
        dout_d = '0;
        doe_n_d = '1;
        if (!serial_mode) begin
            dout_d = par_q[LOW_PINS-1:0]; // RULE_01
            doe_n_d = {LOW_PINS{!out_en}};
        end else begin
            dout_d[PIN_SDO] = sreg_q[WORD-1]; // RULE_03
            dout_d[PIN_SCLK] = sclk_int ^ sck_inv;
            dout_d[PIN_FRAME] = master ? frame : sync_pol; // RULE_12
            dout_d[PIN_OVR] = (ovr_pulse_q != 2'h0);
            doe_n_d[PIN_SDO] = !out_en;
            doe_n_d[PIN_SCLK] = !(out_en && master); // RULE_11
            doe_n_d[PIN_FRAME] = !out_en;
            doe_n_d[PIN_OVR] = !out_en;
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_q <= 1'b0;
            par_q <= '0;
            st_q <= SS_IDLE;
            sreg_q <= '0;
            tick_q <= 8'h0;
            qtr_q <= 2'h0;
            bit_q <= 4'h0;
            scnt_q <= 8'h0;
            sclk_prev_q <= 1'b0;
            ovr_pulse_q <= 2'h0;
            ovr_cnt_q <= 8'h0;
            dout_q <= '0;
            doe_n_q <= '1;
        end else begin
            busy_q <= busy_d;
            par_q <= par_d;
            st_q <= st_d;
            sreg_q <= sreg_d;
            tick_q <= tick_d;
            qtr_q <= qtr_d;
            bit_q <= bit_d;
            scnt_q <= scnt_d;
            sclk_prev_q <= sclk_in;
            ovr_pulse_q <= ovr_pulse_d;
            ovr_cnt_q <= ovr_cnt_d;
            dout_q <= dout_d;
            doe_n_q <= doe_n_d;
        end
    end

    assign d_o = dout_q;
    assign d_oe_n_o = doe_n_q;
    assign d_hi_o = par_q[WORD-1:LOW_PINS]; // RULE_02
    assign busy_o = busy_q;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);

    sequence s_load;
        cnv_done_i && !rst_pin;
    endsequence

    a_busy_rise: assert property (cnv_start_i && !cnv_done_i && !rst_pin |=> busy_o) // RULE_18
        else $error("busy did not rise on start");
    a_busy_fall: assert property (cnv_done_i |=> !busy_o) // RULE_18
        else $error("busy still high after result latched");
    a_hi_bits: assert property (s_load |=> ##1 d_hi_o == $past(coded[WORD-1:LOW_PINS], 2)) // RULE_02
        else $error("upper result bits wrong");
    a_msb_code: assert property (s_load |=> par_q[WORD-1] == ($past(cnv_data_i[WORD-1]) ^ !$past(coding_straight))) // RULE_16
        else $error("msb coding wrong");
    a_par_drive: assert property (!serial_mode && out_en ##1 !serial_mode
                                  |-> d_oe_n_o[11:7] == 5'h0 && d_o[11:7] == $past(par_q[11:7])) // RULE_01
        else $error("parallel bits not driven");
    a_sclk_dir: assert property (slave && $past(slave) |-> d_oe_n_o[PIN_SCLK]) // RULE_11
        else $error("clock pin driven with external clock");
    a_frame_pol: assert property (master && st_q == SS_SHIFT ##1 $past(serial_mode)
                                  |-> d_o[PIN_FRAME] == !$past(sync_pol)) // RULE_13
        else $error("frame marker level wrong");
    sequence s_chain_shift;
        act_edge && !cnv_done_i;
    endsequence

    a_msb_first: assert property ((master && !read_mode) and s_load // RULE_06
                                  |=> st_q == SS_SHIFT && sreg_q[WORD-1] == $past(coded[WORD-1]))
        else $error("first serial bit is not msb");
    a_int_stable: assert property (st_q == SS_SHIFT && qtr_q != 2'h3 && !cnv_done_i && !act_edge // RULE_08
                                   |=> $stable(sreg_q))
        else $error("serial bit moved inside clock period");
    a_slave_hold: assert property (slave && !act_edge && !cnv_done_i && st_q != SS_SHIFT |=> $stable(sreg_q)) // RULE_09
        else $error("slave output changed without active edge");
    a_ovr_pulse: assert property ((slave && reading) and s_load // RULE_15
                                  |=> ovr_pulse_q != 2'h0 ##1 1'b1 ##[1:3] ovr_pulse_q == 2'h0)
        else $error("overrun pulse wrong");
    a_ovr_count: assert property ((slave && reading) and s_load |=> ovr_cnt_q == $past(ovr_cnt_q) + 8'h1) // RULE_15
        else $error("overrun count not advanced");
    a_chain_lsb: assert property (s_chain_shift |=> sreg_q[0] == $past(read_mode)) // RULE_04
        else $error("chain input not shifted in");
    a_sdo_msb: assert property (serial_mode |=> d_o[PIN_SDO] == $past(sreg_q[WORD-1])) // RULE_03
        else $error("serial output is not the register msb");
    a_sclk_out: assert property (master && out_en |=> !d_oe_n_o[PIN_SCLK]) // RULE_11
        else $error("clock pin not driven with internal clock");
    a_frame_idle: assert property (slave |=> d_o[PIN_FRAME] == $past(sync_pol)) // RULE_12
        else $error("frame marker moved with external clock");
endmodule

// >>> verif/aspo_host.sv
// host-side serial reader that clocks results out of the port in slave mode
`timescale 1ns/1ns
module aspo_host (
    input  wire logic        go_i,
    input  wire logic        inv_i,
    input  wire logic [4:0]  nbits_i,
    input  wire logic        sdo_i,
    output logic             sclk_o,
    output logic [15:0]      word_o,
    output logic             done_o
);
    logic run = 1'b0;
    logic ph  = 1'b0;

    // clock stands at its idle level outside a read, so the first edge samples
    assign sclk_o = run ? ph : ~inv_i;

    initial begin
        word_o = 16'h0;
        done_o = 1'b0;
    end

    always @(posedge go_i) begin
        word_o = 16'h0;
        ph = ~inv_i;
        run = 1'b1;
        // keep link edges off the system clock edges so the port's sync delay has margin
        #30;
        for (int i = 0; i < nbits_i; i++) begin
            #200 ph = inv_i;
            word_o = {word_o[14:0], sdo_i};
            #200 ph = ~inv_i;
        end
        run = 1'b0;
        done_o = 1'b1;
        #50 done_o = 1'b0;
    end
endmodule

// >>> verif/aspo_top_bench.sv
// self-checking bench: apb, parallel port, serial slave and serial master
`timescale 1ns/1ns
module aspo_top_bench;
    import aspo_pkg::*;
    logic        clk_i, arst_n_i, psel, penable, pwrite, pready, pslverr, busy_o, cnv_start_i, cnv_done_i;
    logic        reset_pin_i, port_type_select_i, output_coding_select_i, cs_n_i, rd_n_i;
    logic        err, go, hdone, sclk, mon_en, msck, mbit, ovr_seen;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [15:0] cnv_data_i, data, mword, hword, expq[$];
    logic [11:0] d_i, d_o, d_oe_n_o, pins;
    logic [3:0]  d_hi_o;
    logic [4:0]  nbits;
    int          n_errors, samples_checked, seed, mbits;
    event        mdone;

    assign d_i = (d_oe_n_o & {pins[11:10], sclk, pins[8:0]}) | (~d_oe_n_o & d_o);

    aspo_top dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cnv_start_i(cnv_start_i), .cnv_done_i(cnv_done_i), .cnv_data_i(cnv_data_i), .reset_pin_i(reset_pin_i),
        .port_type_select_i(port_type_select_i), .output_coding_select_i(output_coding_select_i),
        .cs_n_i(cs_n_i), .rd_n_i(rd_n_i), .d_i(d_i), .d_o(d_o), .d_oe_n_o(d_oe_n_o), .d_hi_o(d_hi_o),
        .busy_o(busy_o));
    aspo_host host (.go_i(go), .inv_i(pins[PIN_SCKINV]), .nbits_i(nbits), .sdo_i(d_i[PIN_SDO]),
        .sclk_o(sclk), .word_o(hword), .done_o(hdone));

    initial begin
        clk_i = 1'b0;
        forever #25 clk_i = ~clk_i;
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk_i);
        penable <= 1'b1;
        @(posedge clk_i);
        while (pready !== 1'b1)
            @(posedge clk_i);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [15:0] coded(input logic [15:0] v, input logic ob);
        return ob ? v : {~v[15], v[14:0]};
    endfunction

    task automatic settle();
        repeat (6) @(posedge clk_i);
    endtask

    task automatic start_pulse();
        @(posedge clk_i);
        cnv_start_i <= 1'b1;
        @(posedge clk_i);
        cnv_start_i <= 1'b0;
    endtask

    task automatic conv(input logic [15:0] v);
        start_pulse();
        @(posedge clk_i);
        check("busy_high", 32'(busy_o), 1);
        cnv_data_i <= v;
        cnv_done_i <= 1'b1;
        @(posedge clk_i);
        cnv_done_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        check("busy_low", 32'(busy_o), 0);
    endtask

    task automatic read_host(input logic [4:0] n);
        nbits <= n;
        go <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        @(posedge hdone);
        @(posedge clk_i);
    endtask

    always @(posedge hdone)
        check("slave_word", 32'(hword), 32'(expq.pop_front()));

    always @(posedge clk_i) begin
        if (port_type_select_i && pins[PIN_CLKSRC] && d_o[PIN_OVR])
            ovr_seen <= 1'b1;
        if (mon_en && (d_o[PIN_FRAME] ^ pins[PIN_SYNCPOL])) begin
            if (d_o[PIN_SCLK] && !msck) begin
                mbits <= mbits + 1;
                mword <= {mword[14:0], d_o[PIN_SDO]};
                mbit <= d_o[PIN_SDO];
            end
            if (!d_o[PIN_SCLK] && msck)
                check("bit_hold", 32'(d_o[PIN_SDO]), 32'(mbit));
        end else if (mbits != 0) begin
            check("frame_bits", mbits, 16);
            check("master_word", 32'(mword), 32'(expq.pop_front()));
            mbits <= 0;
            -> mdone;
        end
        msck <= d_o[PIN_SCLK];
    end

    initial begin
        #400_000;
        n_errors++;
        close_out();
    end

    initial begin
        {arst_n_i, psel, penable, pwrite, cnv_start_i, cnv_done_i, reset_pin_i, port_type_select_i, rd_n_i} = '0;
        {go, mon_en, msck, mbit, ovr_seen, paddr, pwdata, cnv_data_i, pins, nbits, mword} = '0;
        cs_n_i = 1'b1;
        output_coding_select_i = 1'b1;
        {n_errors, samples_checked, mbits} = '0;
        seed = 80;
        repeat (8) @(posedge clk_i);
        arst_n_i <= 1'b1;
        apb(1'b0, REG_CTRL, 0);
        check("ctrl_reset", rd, 32'(DIV_RST));
        apb(1'b0, 8'h3c, 0);
        check("unmapped", 32'(err), 1);
        data = $random(seed);
        apb(1'b1, REG_CTRL, 32'(data[7:0]));
        apb(1'b0, REG_CTRL, 0);
        check("ctrl_rw", rd, 32'(data[7:0]));
        apb(1'b1, REG_CTRL, 0);
        settle();
        check("par_gated", 32'(d_oe_n_o), 32'hfff);
        cs_n_i <= 1'b0;
        for (int ob = 0; ob < 2; ob++) begin
            output_coding_select_i <= ob[0];
            data = $random(seed);
            settle();
            conv(data);
            repeat (3) @(posedge clk_i);
            check("par_low", 32'(d_o), 32'(coded(data, ob[0]) & 16'h0fff));
            check("par_high", 32'(d_hi_o), 32'(coded(data, ob[0]) >> 12));
            check("par_enable", 32'(d_oe_n_o), 0);
            apb(1'b0, REG_RESULT, 0);
            check("result_reg", rd, 32'(coded(data, ob[0])));
        end
        port_type_select_i <= 1'b1;
        pins[PIN_CLKSRC] <= 1'b1;
        for (int iv = 0; iv < 2; iv++) begin
            // chip-select high while the clock pin changes level, so no false edge is counted
            cs_n_i <= 1'b1;
            pins[PIN_SCKINV] <= iv[0];
            pins[PIN_RDC] <= iv[0];
            output_coding_select_i <= iv[0];
            data = 16'($random(seed));
            settle();
            cs_n_i <= 1'b0;
            settle();
            check("slave_sclk_in", 32'(d_oe_n_o[PIN_SCLK]), 1);
            check("high_pins_out", 32'(d_hi_o), 32'(coded(cnv_data_i, !iv[0]) >> 12));
            expq.push_back(coded(data, iv[0]));
            conv(data);
            read_host(16);
            repeat (10) @(posedge clk_i);
            check("chain_out", 32'(d_o[PIN_SDO]), iv);
        end
        // coding is straight binary here, so a five-bit read yields the top bits as they are
        data = $random(seed);
        expq.push_back({11'h0, data[15:11]});
        conv(data);
        read_host(5);
        ovr_seen = 1'b0;
        data = $random(seed);
        expq.push_back(data);
        conv(data);
        repeat (4) @(posedge clk_i);
        check("overrun_flag", 32'(ovr_seen), 1);
        apb(1'b0, REG_STAT, 0);
        check("overrun_count", 32'(rd[15:8]), 1);
        read_host(16);
        pins[PIN_CLKSRC] <= 1'b0;
        pins[PIN_SCKINV] <= 1'b0;
        for (int pol = 0; pol < 3; pol++) begin
            pins[PIN_SYNCPOL] <= pol[0];
            pins[PIN_RDC] <= pol[1];
            data = $random(seed);
            settle();
            mon_en <= 1'b1;
            check("master_sclk_out", 32'(d_oe_n_o[PIN_SCLK]), 0);
            expq.push_back(data);
            conv(data);
            if (pol[1]) begin
                repeat (20) @(posedge clk_i);
                check("read_held", 32'(d_o[PIN_FRAME] ^ pins[PIN_SYNCPOL]), 0);
                start_pulse();
            end
            @(mdone);
            mon_en <= 1'b0;
        end
        start_pulse();
        reset_pin_i <= 1'b1;
        settle();
        check("abort_busy", 32'(busy_o), 0);
        reset_pin_i <= 1'b0;
        close_out();
    end
endmodule
